// [design/olbt_map.vh]
// Purpose: constants for the optical link bit error rate tester
// Assumes: 250 MHz reference clock, plain Verilog-2005 design
// Notes: sample and bit divider counts derive from the rates below
//
// Function
// - transmit streams on both channels run continuously while test runs
// - pattern source selects one of three modes: static, toggle, noise
// - static mode: each transmit line follows its user control level
// - toggle mode: each transmit line inverts on every bit clock
// - noise mode: uniform white noise scaled by 16-bit amplitude
// - receive sampled at 80 MHz, every second sample valid, 40 MHz
// - compare valid received bits with sent bits, count mismatches
// - simple access: controls drive transmit, status shows receive levels
// - lines fixed: tx2 line 0, tx1 line 1, rx1 line 2, rx2 line 4
// - receive level undefined after power-up until its first edge
// - transmit outputs default to no light during reset
`ifndef OLBT_MAP_VH
`define OLBT_MAP_VH

// =====================================================================
// modes
`define OLBT_MODE_W 2
`define OLBT_MODE_STATIC 2'h0
`define OLBT_MODE_TOGGLE 2'h1
`define OLBT_MODE_NOISE 2'h2

// =====================================================================
// timing
`define OLBT_CLK_MHZ 250
`define OLBT_SAMPLE_MHZ 80
`define OLBT_BIT_MHZ 20
// cycles per 80 MHz tick rounded down (shortest time), at least 1
`define OLBT_SAMPLE_DIV (`OLBT_CLK_MHZ / `OLBT_SAMPLE_MHZ)
// valid samples are every second one
`define OLBT_VALID_EVERY 2
// 80 MHz ticks per transmitted bit
`define OLBT_TICKS_PER_BIT (`OLBT_SAMPLE_MHZ / `OLBT_BIT_MHZ)

// =====================================================================
// line numbers
`define OLBT_LINE_TX2 0
`define OLBT_LINE_TX1 1
`define OLBT_LINE_RX1 2
`define OLBT_LINE_RX2 4

`define OLBT_LFSR_SEED 16'hACE1
`define OLBT_ERR_W 32

`endif

// [design/olbt_top.v]
// Purpose: bit error rate tester for a two-channel optical link
// Assumes: fibre loops tx1 to rx2 and tx2 to rx1; receive lines async
// Notes: 80 MHz sample tick is derived from the 250 MHz clock by counting
`timescale 1ns/10ps
`include "olbt_map.vh"

module olbt_top #(
    parameter DELAY_W = 4,
    parameter AMP_W = 16
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_test_run,
    input wire [1:0] i_mode,
    input wire i_static_tx1,
    input wire i_static_tx2,
    input wire [AMP_W-1:0] i_noise_amp,
    input wire [DELAY_W-1:0] i_loop_delay,
    input wire i_clear_count,
    input wire [7:0] i_line_in,
    output reg [7:0] o_line_out,
    output reg [7:0] o_line_oe,
    output reg o_rx1_level,
    output reg o_rx2_level,
    output reg o_rx1_defined,
    output reg o_rx2_defined,
    output reg o_bit_strobe,
    output reg [`OLBT_ERR_W-1:0] o_bit_count,
    output reg [`OLBT_ERR_W-1:0] o_err_count_rx1,
    output reg [`OLBT_ERR_W-1:0] o_err_count_rx2
);

// =====================================================================
// receive synchronisers
reg [1:0] rx1_sync_r;
reg [1:0] rx2_sync_r;
reg rx1_prev_r;
reg rx2_prev_r;

// two flops per line before any logic reads the level
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        rx1_sync_r <= 2'h0;
        rx2_sync_r <= 2'h0;
    end else begin
        rx1_sync_r <= {rx1_sync_r[0], i_line_in[`OLBT_LINE_RX1]};
        rx2_sync_r <= {rx2_sync_r[0], i_line_in[`OLBT_LINE_RX2]};
    end
end

// =====================================================================
// sample tick generation
reg [3:0] div_cnt_r;
reg sample_tick_r;
reg [1:0] tick_cnt_r;
reg valid_phase_r;

// last counts of both dividers, cut to the counter widths on purpose
localparam [31:0] DIV_LAST = `OLBT_SAMPLE_DIV - 1;
localparam [31:0] TICK_LAST = `OLBT_TICKS_PER_BIT - 1;

// 80 MHz tick by a modulo counter; fixed period of 3 cycles, no jitter
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        div_cnt_r <= 4'h0;
        sample_tick_r <= 1'b0;
        tick_cnt_r <= 2'h0;
        valid_phase_r <= 1'b0;
    end else begin
        sample_tick_r <= 1'b0;
        if (div_cnt_r == DIV_LAST[3:0]) begin
            div_cnt_r <= 4'h0;
            sample_tick_r <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 4'h1;
        end
        if (sample_tick_r) begin
            tick_cnt_r <= tick_cnt_r + 2'h1;
            valid_phase_r <= ~valid_phase_r;
        end
    end
end

wire bit_tick = sample_tick_r &&
    (tick_cnt_r == TICK_LAST[1:0]);
// every second 80 MHz sample is valid, giving 40 MHz; the comparator
// only uses the one with tick_cnt_r at 1, half a bit after the 20 MHz bit boundary
wire sample_valid = sample_tick_r && valid_phase_r;
wire bit_sample = sample_valid && (tick_cnt_r == 2'h1);

// =====================================================================
// pattern generation
reg [15:0] lfsr_r;
reg tx1_r;
reg tx2_r;
reg tx1_nxt;
reg tx2_nxt;
wire [31:0] noise_prod = {16'h0000, lfsr_r} * {16'h0000, i_noise_amp};
// tx1: scaled noise above half of full scale reads as a one; tx2 takes bit 30
wire noise_bit1 = noise_prod[31];
wire noise_bit2 = noise_prod[30];

// select next transmit bits from the active mode
always @* begin
    tx1_nxt = tx1_r;
    tx2_nxt = tx2_r;
    case (i_mode)
        `OLBT_MODE_STATIC: begin
            tx1_nxt = i_static_tx1;
            tx2_nxt = i_static_tx2;
        end
        `OLBT_MODE_TOGGLE: begin
            tx1_nxt = ~tx1_r;
            tx2_nxt = ~tx2_r;
        end
        `OLBT_MODE_NOISE: begin
            tx1_nxt = noise_bit1;
            tx2_nxt = noise_bit2;
        end
        default: begin
            tx1_nxt = 1'b0;
            tx2_nxt = 1'b0;
        end
    endcase
end

// bits advance on each bit clock while the test runs, without gaps
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        lfsr_r <= `OLBT_LFSR_SEED;
        tx1_r <= 1'b0;
        tx2_r <= 1'b0;
    end else if (bit_tick && i_test_run) begin
        lfsr_r <= {lfsr_r[14:0],
            lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        tx1_r <= tx1_nxt;
        tx2_r <= tx2_nxt;
    end else if (!i_test_run) begin
        // static control acts at once when no test runs
        tx1_r <= i_static_tx1;
        tx2_r <= i_static_tx2;
    end
end

// =====================================================================
// output lines
// line mapping fixed; other lines stay undriven
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_line_out <= 8'h00;
        o_line_oe <= 8'h00;
    end else begin
        o_line_out <= 8'h00;
        o_line_out[`OLBT_LINE_TX2] <= tx2_r;
        o_line_out[`OLBT_LINE_TX1] <= tx1_r;
        o_line_oe <= 8'h00;
        o_line_oe[`OLBT_LINE_TX2] <= 1'b1;
        o_line_oe[`OLBT_LINE_TX1] <= 1'b1;
    end
end

// =====================================================================
// reference delay lines
reg [(1<<DELAY_W)-1:0] ref1_r;
reg [(1<<DELAY_W)-1:0] ref2_r;

// shift sent bits on each bit tick; tap chosen by measured latency
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        ref1_r <= {(1<<DELAY_W){1'b0}};
        ref2_r <= {(1<<DELAY_W){1'b0}};
    end else if (bit_tick) begin
        ref1_r <= {ref1_r[(1<<DELAY_W)-2:0], tx1_r};
        ref2_r <= {ref2_r[(1<<DELAY_W)-2:0], tx2_r};
    end
end

// tap 0 is the bit now being sent, tap k the one sent k bits earlier;
// a short loop lands inside the very bit that caused it, so keep tap 0
wire [(1<<DELAY_W)-1:0] ref1_tap = {ref1_r[(1<<DELAY_W)-2:0], tx1_r};
wire [(1<<DELAY_W)-1:0] ref2_tap = {ref2_r[(1<<DELAY_W)-2:0], tx2_r};

// cross-connected fibre: rx1 sees tx2, rx2 sees tx1
wire exp_rx1 = ref2_tap[i_loop_delay];
wire exp_rx2 = ref1_tap[i_loop_delay];

// =====================================================================
// receive status and error counting
reg [2:0] rx_arm_r;

// error counts run only once a line has shown its first edge; the edge test waits
// until the synchronisers have refilled, else a high line fakes an edge
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        rx_arm_r <= 3'h0;
        rx1_prev_r <= 1'b0;
        rx2_prev_r <= 1'b0;
        o_rx1_level <= 1'b0;
        o_rx2_level <= 1'b0;
        o_rx1_defined <= 1'b0;
        o_rx2_defined <= 1'b0;
        o_bit_strobe <= 1'b0;
        o_bit_count <= {`OLBT_ERR_W{1'b0}};
        o_err_count_rx1 <= {`OLBT_ERR_W{1'b0}};
        o_err_count_rx2 <= {`OLBT_ERR_W{1'b0}};
    end else begin
        rx_arm_r <= {rx_arm_r[1:0], 1'b1};
        rx1_prev_r <= rx1_sync_r[1];
        rx2_prev_r <= rx2_sync_r[1];
        o_rx1_level <= rx1_sync_r[1];
        o_rx2_level <= rx2_sync_r[1];
        if (rx_arm_r[2] && (rx1_sync_r[1] != rx1_prev_r))
            o_rx1_defined <= 1'b1;
        if (rx_arm_r[2] && (rx2_sync_r[1] != rx2_prev_r))
            o_rx2_defined <= 1'b1;
        o_bit_strobe <= bit_sample && i_test_run;
        if (i_clear_count) begin
            o_bit_count <= {`OLBT_ERR_W{1'b0}};
            o_err_count_rx1 <= {`OLBT_ERR_W{1'b0}};
            o_err_count_rx2 <= {`OLBT_ERR_W{1'b0}};
        end else if (bit_sample && i_test_run) begin
            o_bit_count <= o_bit_count + 1'b1;
            if (o_rx1_defined && (rx1_sync_r[1] != exp_rx1))
                o_err_count_rx1 <= o_err_count_rx1 + 1'b1;
            if (o_rx2_defined && (rx2_sync_r[1] != exp_rx2))
                o_err_count_rx2 <= o_err_count_rx2 + 1'b1;
        end
    end
end

endmodule // olbt_top

// [test/olbt_loop_model.sv]
// Purpose: fibre loopback partner for the error rate tester
// Assumes: channels cross-connected, spare lines pulled low
// Notes: i_flip inverts receive one to inject bit errors
`timescale 1ns/10ps
module olbt_loop_model (
    input wire logic i_clk,
    input wire logic [7:0] i_line_out,
    input wire logic [7:0] i_line_oe,
    input wire logic i_flip,
    output logic [7:0] o_line_in
);
// =====
// flight time of two clocks; a released driver gives no light
logic [1:0] tx2_r = 2'h0;
logic [1:0] tx1_r = 2'h0;
always @(posedge i_clk) begin
    tx2_r <= {tx2_r[0], i_line_out[0] & i_line_oe[0]};
    tx1_r <= {tx1_r[0], i_line_out[1] & i_line_oe[1]};
end
assign o_line_in = {3'h0, tx1_r[1], 1'h0, tx2_r[1] ^ i_flip, 2'h0};
endmodule // olbt_loop_model

// [test/olbt_asserts.sv]
// Purpose: port checker for the optical link error rate tester
// Assumes: one clock, synchronous active-high reset
// Notes: latencies follow the registered port timing of the block
`timescale 1ns/10ps
module olbt_asserts (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_test_run,
    input wire [1:0] i_mode,
    input wire i_static_tx1,
    input wire [7:0] i_line_in,
    input wire [7:0] o_line_out,
    input wire [7:0] o_line_oe,
    input wire o_rx1_level,
    input wire o_rx1_defined,
    input wire o_bit_strobe,
    input wire [31:0] o_bit_count,
    input wire [31:0] o_err_count_rx1
);
// =====
// checks
default clocking @(posedge i_ref_clk); endclocking
default disable iff (i_rst);
a_reset_dark: assert property ($past(i_rst) |-> o_line_oe == 8'h00)
    else $error("driver on after reset");
a_oe_drive: assert property (!$past(i_rst) |-> o_line_oe == 8'h03)
    else $error("wrong driver enables");
a_spare_low: assert property (o_line_out[7:2] == 6'h00)
    else $error("spare line driven");
a_static_follow: assert property ((!i_test_run && i_mode == 2'h0 &&
    $stable(i_static_tx1))[*3] |-> o_line_out[1] == i_static_tx1)
    else $error("tx1 not following control");
a_rx_status: assert property ($stable(i_line_in[2])[*4]
    |-> o_rx1_level == i_line_in[2])
    else $error("rx1 status stale");
a_defined_held: assert property (o_rx1_defined |=> o_rx1_defined)
    else $error("defined flag dropped");
a_undef_quiet: assert property (!o_rx1_defined
    |-> o_err_count_rx1 == 32'h0)
    else $error("errors before first edge");
a_bit_pace: assert property (o_bit_strobe
    |=> (!o_bit_strobe)[*8] ##1 (!o_bit_strobe)[*3])
    else $error("bit strobe too close");
a_count_step: assert property ($changed(o_bit_count) && o_bit_count
    != 32'h0 |-> o_bit_count == $past(o_bit_count) + 32'h1)
    else $error("bit count jumped");
c_strobe: cover property (o_bit_strobe);
c_err: cover property (o_err_count_rx1 != 32'h0);
c_def: cover property ($rose(o_rx1_defined));
endmodule // olbt_asserts
bind olbt_top olbt_asserts chk_u (.i_ref_clk, .i_rst, .i_test_run,
    .i_mode, .i_static_tx1, .i_line_in, .o_line_out, .o_line_oe,
    .o_rx1_level, .o_rx1_defined, .o_bit_strobe, .o_bit_count,
    .o_err_count_rx1);

// [test/olbt_top_tb.sv]
// Purpose: bench for the optical link error rate tester
// Assumes: loop model cross-connects the two channels
// Notes: a delay sweep finds the loop latency
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
    $display("unexpected %0t mismatch", $time); end end
module olbt_top_tb;
// =====
// stimulus and wiring
reg clk = 0, rst = 1, run = 0, st1 = 0, st2 = 0, clr = 0, flip = 0;
reg [1:0] mode = 2'h0;
reg [15:0] amp = 16'h0000;
reg [3:0] dly = 4'h0;
wire [7:0] lo, oe, li;
wire l1, l2, d1, d2, stb;
wire [31:0] bc, e1, e2;
int bad_count = 0, cmp_count = 0, n, best = -1, bad_d = 0;
always #2 clk = ~clk;
olbt_top #(.DELAY_W(4), .AMP_W(16)) dut_u (.i_ref_clk(clk), .i_rst(rst),
    .i_test_run(run), .i_mode(mode), .i_static_tx1(st1),
    .i_static_tx2(st2), .i_noise_amp(amp), .i_loop_delay(dly),
    .i_clear_count(clr), .i_line_in(li), .o_line_out(lo),
    .o_line_oe(oe), .o_rx1_level(l1), .o_rx2_level(l2),
    .o_rx1_defined(d1), .o_rx2_defined(d2), .o_bit_strobe(stb),
    .o_bit_count(bc), .o_err_count_rx1(e1), .o_err_count_rx2(e2));
olbt_loop_model lp_u (.i_clk(clk), .i_line_out(lo), .i_line_oe(oe),
    .i_flip(flip), .o_line_in(li));
task cyc(input int k);
    repeat (k) @(posedge clk);
endtask
// clear, then let k bits through
task bits(input int k);
    clr <= 1;
    cyc(2);
    clr <= 0;
    cyc(12 * k);
endtask
// tx1 transitions over ten bit periods
task edges(output int t);
    reg p;
    t = 0;
    p = lo[1];
    repeat (120) begin
        @(posedge clk);
        if (lo[1] !== p) t++;
        p = lo[1];
    end
endtask
task print_verdict;
    if (bad_count == 0 && cmp_count > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask
task wstb;
    int k;
    for (k = 0; k < 40 && stb !== 1'h1; k++) @(posedge clk);
    if (k == 40) begin
        bad_count++;
        print_verdict;
    end
endtask
// main sequence: one scenario per group of lines
initial begin
    cyc(10);
    `CHK(oe, 8'h00)
    rst <= 0;
    st1 <= 1;
    cyc(12);
    `CHK(lo[1:0], 2'h2)
    `CHK({l2, d2, d1}, 3'h6)
    st1 <= 0;
    st2 <= 1;
    cyc(12);
    `CHK({lo[1:0], l1, l2, d1}, 5'h0D)
    mode <= 2'h1;
    run <= 1;
    wstb;
    edges(n);
    `CHK(n, 10)
    mode <= 2'h2;
    amp <= 16'hFFFF;
    for (n = 0; n < 16; n++) begin
        dly <= n[3:0];
        bits(30);
        if (e1 === 32'h0 && e2 === 32'h0 && bc !== 32'h0) best = n;
        else bad_d++;
    end
    `CHK(best >= 0, 1'h1)
    `CHK(bad_d > 0, 1'h1)
    dly <= best[3:0];
    flip <= 1;
    bits(20);
    `CHK({e1 !== 32'h0, e2}, 33'h100000000)
    flip <= 0;
    clr <= 1;
    cyc(3);
    `CHK(bc, 32'h0)
    clr <= 0;
    amp <= 16'h0000;
    cyc(30);
    edges(n);
    `CHK(n, 0)
    run <= 0;
    cyc(40);
    force_keep();
    mode <= 2'h3;
    run <= 1;
    cyc(30);
    `CHK(lo[1:0], 2'h0)
    rst <= 1;
    cyc(2);
    `CHK(lo, 8'h00)
    rst <= 0;
    cyc(4);
    print_verdict;
end
// bit count holds still while the test is off
task force_keep;
    reg [31:0] v;
    v = bc;
    cyc(40);
    `CHK(bc, v)
endtask
endmodule // olbt_top_tb
